// ==== hdl/acs_consts.svh ====
// offsets, field positions, reset values and counts of the sequencer
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ACS_ADDR_CTRL0   8'h1F
`define ACS_ADDR_CONFIG  8'h9F
`define ACS_ADDR_RES_HI  8'h1E
`define ACS_ADDR_RES_LO  8'h9E
`define ACS_ADDR_ANALOG_PIN_SELECT   8'h9B
`define ACS_ADDR_FLAG    8'h0C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ACS_POWER_BIT    0
`define ACS_GO_BIT       2
`define ACS_CHAN_LSB     3
`define ACS_SRC_LSB      6
`define ACS_VREF_LSB     4
`define ACS_DIVHI_BIT    6
`define ACS_JUSTIFY_BIT  7
`define ACS_DONE_BIT     6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ACS_ANALOG_PIN_SELECT_RST    7'h7F
`define ACS_RES_RST      8'h00

// ----------------------------------------------------------------
// bit period counts and the rc clock source select code
// ----------------------------------------------------------------
`define ACS_CONV_LAST    4'h8
`define ACS_HOLD_LAST    4'h1
`define ACS_SRC_RC       2'h3
`define ACS_CNT_START    7'h01
`define ACS_DIV2_LAST    7'h01
`define ACS_DIV8_LAST    7'h07
`define ACS_DIV32_LAST   7'h1F
`define ACS_DIV4_LAST    7'h03
`define ACS_DIV16_LAST   7'h0F
`define ACS_DIV64_LAST   7'h3F

`endif

// ==== hdl/acs_pkg.sv ====
// types of the conversion sequencer
package acs_pkg;

    typedef enum logic [2:0] {
        acs_st_idle = 3'b001,
        acs_st_conv = 3'b010,
        acs_st_hold = 3'b100
    } acs_state_t;

endpackage : acs_pkg

// ==== hdl/acs_bit_clock.sv ====
// bit period tick generator: oscillator divider or synchronised rc clock
`timescale 1ns/1ps
`include "acs_consts.svh"

module acs_bit_clock
    import acs_pkg::*;
#(
    parameter int CNT_W = 7
)
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic       restart,
    input  wire logic [2:0] clock_sel,
    input  wire logic       rc_osc_in,
    output logic            tick_r
);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             rc_meta_r;
    logic             rc_sync_r;
    logic             rc_prev_r;
    logic             tick_nxt;
    logic [CNT_W-1:0] last_w;

    // ----------------------------------------------------------------
    // divider selection
    // ----------------------------------------------------------------
    function automatic logic [CNT_W-1:0] div_last(input logic [2:0] sel);
        case (sel)
            3'h0:    div_last = CNT_W'(`ACS_DIV2_LAST);
            3'h1:    div_last = CNT_W'(`ACS_DIV8_LAST);
            3'h2:    div_last = CNT_W'(`ACS_DIV32_LAST);
            3'h4:    div_last = CNT_W'(`ACS_DIV4_LAST);
            3'h5:    div_last = CNT_W'(`ACS_DIV16_LAST);
            3'h6:    div_last = CNT_W'(`ACS_DIV64_LAST);
            default: div_last = CNT_W'(0);
        endcase
    endfunction : div_last

    assign last_w = div_last(clock_sel);

    always_comb begin
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        if (!run || restart) begin
            // preload: registered tick then lands one bit period after start
            cnt_nxt = CNT_W'(`ACS_CNT_START);
        end else if (clock_sel[1:0] == `ACS_SRC_RC) begin
            tick_nxt = rc_sync_r & ~rc_prev_r;
        end else if (cnt_r == last_w) begin
            cnt_nxt  = '0;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + CNT_W'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_r     <= '0;
            tick_r    <= 1'b0;
            rc_meta_r <= 1'b0;
            rc_sync_r <= 1'b0;
            rc_prev_r <= 1'b0;
        end else begin
            cnt_r     <= cnt_nxt;
            tick_r    <= tick_nxt;
            rc_meta_r <= rc_osc_in;
            rc_sync_r <= rc_meta_r;
            rc_prev_r <= rc_sync_r;
        end
    end

endmodule : acs_bit_clock

// ==== hdl/acs_sequencer.sv ====
// conversion sequencer of the 10-bit converter with its registers
`timescale 1ns/1ps
`include "acs_consts.svh"

module acs_sequencer
    import acs_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic [7:0]      reg_rdata_r,
    input  wire logic       rc_osc_in,
    input  wire logic [9:0] sar_result,
    output logic [2:0]      input_channel_select_r,
    output logic [6:0]      analog_pin_select_r,
    output logic [1:0]      vref_select_r,
    output logic            sample_connect_r,
    output logic            converting_r,
    output logic            conversion_done_flag_r
);

    acs_state_t state_r, state_nxt;
    logic [3:0] bit_cnt_r, bit_cnt_nxt;
    logic       go_r, go_nxt, done_nxt;
    logic       power_r, power_nxt;
    logic [1:0] src_sel_r, src_sel_nxt, vref_nxt;
    logic [2:0] chan_nxt;
    logic       justify_r, justify_nxt;
    logic       divhi_r, divhi_nxt;
    logic [6:0] analog_pin_select_nxt;
    logic [7:0] res_hi_r, res_hi_nxt;
    logic [7:0] res_lo_r, res_lo_nxt;
    logic [7:0] rdata_nxt;
    logic       sample_nxt, converting_nxt;
    logic       tick_w, restart_w, conv_done_w, wr_ctrl0_w;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    assign wr_ctrl0_w = reg_write && hit(reg_addr, `ACS_ADDR_CTRL0);

    acs_bit_clock #(
        .CNT_W (7)
    ) u_bit_clock (
        .clock     (clock),
        .rst       (rst),
        .run       (state_r != acs_st_idle),
        .restart   (restart_w),
        .clock_sel ({divhi_r, src_sel_r}),
        .rc_osc_in (rc_osc_in),
        .tick_r    (tick_w)
    );

    // ----------------------------------------------------------------
    // register writes and sequencing
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt   = state_r;
        bit_cnt_nxt = bit_cnt_r;
        go_nxt      = go_r;
        power_nxt   = power_r;
        src_sel_nxt = src_sel_r;
        chan_nxt    = input_channel_select_r;
        justify_nxt = justify_r;
        divhi_nxt   = divhi_r;
        vref_nxt    = vref_select_r;
        analog_pin_select_nxt   = analog_pin_select_r;
        res_hi_nxt  = res_hi_r;
        res_lo_nxt  = res_lo_r;
        done_nxt    = conversion_done_flag_r;
        restart_w   = 1'b0;
        conv_done_w = 1'b0;
        if (wr_ctrl0_w) begin
            power_nxt   = reg_wdata[`ACS_POWER_BIT];
            src_sel_nxt = reg_wdata[`ACS_SRC_LSB +: 2];
            chan_nxt    = reg_wdata[`ACS_CHAN_LSB +: 3];
        end
        if (reg_write && hit(reg_addr, `ACS_ADDR_CONFIG)) begin
            justify_nxt = reg_wdata[`ACS_JUSTIFY_BIT];
            divhi_nxt   = reg_wdata[`ACS_DIVHI_BIT];
            vref_nxt    = reg_wdata[`ACS_VREF_LSB +: 2];
        end
        if (reg_write && hit(reg_addr, `ACS_ADDR_ANALOG_PIN_SELECT))
            analog_pin_select_nxt = reg_wdata[6:0];
        if (reg_write && hit(reg_addr, `ACS_ADDR_RES_HI))
            res_hi_nxt = reg_wdata;
        if (reg_write && hit(reg_addr, `ACS_ADDR_RES_LO))
            res_lo_nxt = reg_wdata;
        if (reg_write && hit(reg_addr, `ACS_ADDR_FLAG))
            done_nxt = reg_wdata[`ACS_DONE_BIT];
        case (state_r)
            acs_st_idle: begin
                if (wr_ctrl0_w && reg_wdata[`ACS_GO_BIT] && power_r &&
                    power_nxt) begin
                    state_nxt   = acs_st_conv;
                    go_nxt      = 1'b1;
                    bit_cnt_nxt = 4'h0;
                end
            end
            acs_st_conv: begin
                if (!power_nxt) begin
                    state_nxt = acs_st_idle;
                    go_nxt    = 1'b0;
                    restart_w = 1'b1;
                end else if (wr_ctrl0_w && !reg_wdata[`ACS_GO_BIT]) begin
                    state_nxt   = acs_st_hold;
                    go_nxt      = 1'b0;
                    bit_cnt_nxt = 4'h0;
                    restart_w   = 1'b1;
                end else if (tick_w) begin
                    if (bit_cnt_r == `ACS_CONV_LAST) begin
                        conv_done_w = 1'b1;
                        state_nxt   = acs_st_hold;
                        go_nxt      = 1'b0;
                        bit_cnt_nxt = 4'h0;
                        done_nxt    = 1'b1;
                        if (justify_r) begin
                            res_hi_nxt = {6'h00, sar_result[9:8]};
                            res_lo_nxt = sar_result[7:0];
                        end else begin
                            res_hi_nxt = sar_result[9:2];
                            res_lo_nxt = {sar_result[1:0], 6'h00};
                        end
                    end else begin
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end
                end
            end
            acs_st_hold: begin
                if (!power_nxt) begin
                    state_nxt = acs_st_idle;
                end else if (tick_w) begin
                    if (bit_cnt_r == `ACS_HOLD_LAST) begin
                        state_nxt = acs_st_idle;
                    end else begin
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end
                end
            end
            default: begin
                state_nxt = acs_st_idle;
                go_nxt    = 1'b0;
            end
        endcase
        sample_nxt     = (state_nxt == acs_st_idle) && power_nxt;
        converting_nxt = (state_nxt == acs_st_conv);
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_read) begin
            case (reg_addr)
                `ACS_ADDR_CTRL0:  rdata_nxt = {src_sel_r,
                    input_channel_select_r, go_r, 1'b0, power_r};
                `ACS_ADDR_CONFIG: rdata_nxt = {justify_r, divhi_r,
                    vref_select_r, 4'h0};
                `ACS_ADDR_ANALOG_PIN_SELECT:  rdata_nxt = {1'b0, analog_pin_select_r};
                `ACS_ADDR_RES_HI: rdata_nxt = res_hi_r;
                `ACS_ADDR_RES_LO: rdata_nxt = res_lo_r;
                `ACS_ADDR_FLAG:   rdata_nxt = {1'b0,
                    conversion_done_flag_r, 6'h00};
                default:          rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r                <= acs_st_idle;
            bit_cnt_r              <= 4'h0;
            go_r                   <= 1'b0;
            power_r                <= 1'b0;
            src_sel_r              <= 2'h0;
            input_channel_select_r <= 3'h0;
            justify_r              <= 1'b0;
            divhi_r                <= 1'b0;
            vref_select_r          <= 2'h0;
            analog_pin_select_r    <= `ACS_ANALOG_PIN_SELECT_RST;
            res_hi_r               <= `ACS_RES_RST;
            res_lo_r               <= `ACS_RES_RST;
            conversion_done_flag_r <= 1'b0;
            reg_rdata_r            <= 8'h00;
            sample_connect_r       <= 1'b0;
            converting_r           <= 1'b0;
        end else begin
            state_r                <= state_nxt;
            bit_cnt_r              <= bit_cnt_nxt;
            go_r                   <= go_nxt;
            power_r                <= power_nxt;
            src_sel_r              <= src_sel_nxt;
            input_channel_select_r <= chan_nxt;
            justify_r              <= justify_nxt;
            divhi_r                <= divhi_nxt;
            vref_select_r          <= vref_nxt;
            analog_pin_select_r    <= analog_pin_select_nxt;
            res_hi_r               <= res_hi_nxt;
            res_lo_r               <= res_lo_nxt;
            conversion_done_flag_r <= done_nxt;
            reg_rdata_r            <= rdata_nxt;
            sample_connect_r       <= sample_nxt;
            converting_r           <= converting_nxt;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_done_flag_set: assert property (
        conv_done_w |=> conversion_done_flag_r && !go_r)
        else $error("done flag or go bit wrong after completion");

    a_result_right: assert property (
        conv_done_w && justify_r |=> res_hi_r[7:2] == 6'h00 &&
        {res_hi_r[1:0], res_lo_r} == $past(sar_result))
        else $error("right justified result wrong");

    a_result_left: assert property (
        conv_done_w && !justify_r |=> res_lo_r[5:0] == 6'h00 &&
        {res_hi_r, res_lo_r[7:6]} == $past(sar_result))
        else $error("left justified result wrong");

    a_bit_count_max: assert property (
        state_r == acs_st_conv |-> bit_cnt_r <= `ACS_CONV_LAST)
        else $error("conversion ran past nine bit periods");

    a_div2_period: assert property (
        state_r == acs_st_conv && tick_w && !conv_done_w &&
        {divhi_r, src_sel_r} == 3'h0 && $stable({divhi_r, src_sel_r})
        && !wr_ctrl0_w |=> !tick_w ##1 (tick_w || $past(restart_w)))
        else $error("two period bit clock wrong");

    a_hold_after_done: assert property (
        conv_done_w |=> state_r == acs_st_hold [*2])
        else $error("recovery gap too short");

    a_cap_off_hold: assert property (
        state_r != acs_st_idle |-> !sample_connect_r)
        else $error("capacitor connected outside acquisition");

    a_abort_keeps: assert property (
        state_r == acs_st_conv && wr_ctrl0_w && power_nxt &&
        !reg_wdata[`ACS_GO_BIT] |=> state_r == acs_st_hold && !go_r &&
        $stable(res_hi_r) && $stable(res_lo_r))
        else $error("abort changed result or skipped gap");

    a_go_starts: assert property (
        state_r == acs_st_idle && power_r && wr_ctrl0_w &&
        reg_wdata[`ACS_GO_BIT] && reg_wdata[`ACS_POWER_BIT] |=>
        go_r && converting_r)
        else $error("go did not start conversion");

    a_unmapped_zero: assert property (
        reg_read && !(reg_addr inside {`ACS_ADDR_CTRL0, `ACS_ADDR_CONFIG,
        `ACS_ADDR_RES_HI, `ACS_ADDR_RES_LO, `ACS_ADDR_ANALOG_PIN_SELECT,
        `ACS_ADDR_FLAG}) |=> reg_rdata_r == 8'h00)
        else $error("unmapped read not zero");

    c_full_conv: cover property (conv_done_w);
    c_abort: cover property (state_r == acs_st_conv ##1
        state_r == acs_st_hold && !conversion_done_flag_r);
    c_back_to_idle: cover property (state_r == acs_st_hold ##1
        state_r == acs_st_idle);

endmodule : acs_sequencer

// ==== tb/test_adc_conversion_sequencer.sv ====
// self-checking testbench of the conversion sequencer
`timescale 1ns/1ps
`include "acs_consts.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end

module test_adc_conversion_sequencer
    import acs_pkg::*;
;
    typedef struct {
        string      nm;
        logic [7:0] exp;
    } acs_note_t;

    logic       clock;
    logic       rst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_write;
    logic       reg_read;
    logic [7:0] reg_rdata_r;
    logic       rc_osc_in;
    logic [9:0] sar_result;
    logic [2:0] input_channel_select_r;
    logic [6:0] analog_pin_select_r;
    logic [1:0] vref_select_r;
    logic       sample_connect_r;
    logic       converting_r;
    logic       conversion_done_flag_r;
    logic       rd_d;
    logic       armed;
    logic [7:0] res_hi;
    logic [7:0] res_lo;
    int         errors;
    int         n_tests;
    int         seed;
    int         conv_cnt;
    int         hold_cnt;
    acs_note_t  rd_q[$];
    localparam int DIV_T [6] = '{2, 8, 32, 4, 16, 64};

    acs_sequencer u_dut (
        .clock                  (clock),
        .rst                    (rst),
        .reg_addr               (reg_addr),
        .reg_wdata              (reg_wdata),
        .reg_write              (reg_write),
        .reg_read               (reg_read),
        .reg_rdata_r            (reg_rdata_r),
        .rc_osc_in              (rc_osc_in),
        .sar_result             (sar_result),
        .input_channel_select_r (input_channel_select_r),
        .analog_pin_select_r    (analog_pin_select_r),
        .vref_select_r          (vref_select_r),
        .sample_connect_r       (sample_connect_r),
        .converting_r           (converting_r),
        .conversion_done_flag_r (conversion_done_flag_r)
    );

    // ----------------------------------------------------------------
    // clock, rc oscillator of about 4 us, watchdog
    // ----------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    always begin
        repeat (20) @(posedge clock);
        rc_osc_in <= ~rc_osc_in;
    end

    initial begin
        #(30000 * 100);
        errors++;
        $display("watchdog expired");
        end_sim();
    end

    // ----------------------------------------------------------------
    // read data watcher and bit period counters
    // ----------------------------------------------------------------
    always @(posedge clock) rd_d <= reg_read;

    always @(negedge clock) begin
        acs_note_t n;
        if (rd_d) begin
            if (rd_q.size() == 0) begin
                errors++;
                $display("mismatch read none expected");
            end else begin
                n = rd_q.pop_front();
                `CHK(n.nm, n.exp, reg_rdata_r)
            end
        end
        if (armed && converting_r === 1'b1) conv_cnt++;
        else if (armed && sample_connect_r === 1'b0) hold_cnt++;
    end

    // ----------------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        rd_q.push_back('{nm, e});
        @(posedge clock);
        reg_read <= 1'b0;
    endtask : rd

    task automatic wait_idle();
        int k;
        k = 0;
        @(negedge clock);
        while (sample_connect_r !== 1'b1 && k < 3000) begin
            @(negedge clock);
            k++;
        end
        armed = 1'b0;
        `CHK("idle wait", 1'b1, k < 3000)
    endtask : wait_idle

    // ----------------------------------------------------------------
    // one full conversion with a given clock select
    // ----------------------------------------------------------------
    task automatic conv(input logic dh, input logic [1:0] src, input int d);
        logic       j;
        logic [2:0] ch;
        logic [9:0] v;
        int         lo;
        j  = 1'($random(seed));
        ch = 3'($unsigned($random(seed)) % 7);
        v  = 10'($random(seed));
        lo = (src == `ACS_SRC_RC) ? d : 2 * d;
        sar_result <= v;
        wr(`ACS_ADDR_CONFIG, {j, dh, 6'h10});
        wr(`ACS_ADDR_CTRL0, {src, ch, 3'b001});
        repeat (4) @(posedge clock);
        conv_cnt = 0;
        hold_cnt = 0;
        armed    = 1'b1;
        wr(`ACS_ADDR_CTRL0, {src, ch, 3'b101});
        rd("go busy", `ACS_ADDR_CTRL0, {src, ch, 3'b101});
        `CHK("channel", ch, input_channel_select_r)
        `CHK("vref", 2'h1, vref_select_r)
        wait_idle();
        if (src == `ACS_SRC_RC) begin
            `CHK("rc length", 1'b1, conv_cnt inside {[8*d:9*d+4]})
        end else begin
            `CHK("length", 9 * d, conv_cnt)
        end
        `CHK("hold", 1'b1, hold_cnt >= lo && hold_cnt <= 2*d+4)
        `CHK("done port", 1'b1, conversion_done_flag_r)
        res_hi = j ? {6'h00, v[9:8]} : v[9:2];
        res_lo = j ? v[7:0] : {v[1:0], 6'h00};
        rd("go clear", `ACS_ADDR_CTRL0, {src, ch, 3'b001});
        rd("result hi", `ACS_ADDR_RES_HI, res_hi);
        rd("result lo", `ACS_ADDR_RES_LO, res_lo);
        rd("flag", `ACS_ADDR_FLAG, 8'h40);
        wr(`ACS_ADDR_FLAG, 8'h00);
        @(negedge clock);
        `CHK("flag clear", 1'b0, conversion_done_flag_r)
        $display("test conversion src %0d high %0d done", src, dh);
    endtask : conv

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        rc_osc_in = 1'b0;
        sar_result = 10'h000;
        armed = 1'b0;
        errors = 0;
        n_tests = 0;
        conv_cnt = 0;
        hold_cnt = 0;
        seed = 65732;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd("analog_pin_select rst", `ACS_ADDR_ANALOG_PIN_SELECT, 8'h7F);
        rd("ctrl0 rst", `ACS_ADDR_CTRL0, 8'h00);
        rd("config rst", `ACS_ADDR_CONFIG, 8'h00);
        rd("res hi rst", `ACS_ADDR_RES_HI, 8'h00);
        rd("res lo rst", `ACS_ADDR_RES_LO, 8'h00);
        rd("flag rst", `ACS_ADDR_FLAG, 8'h00);
        rd("unmapped", 8'h55, 8'h00);
        `CHK("sample rst", 1'b0, sample_connect_r)
        wr(`ACS_ADDR_ANALOG_PIN_SELECT, 8'hAA);
        rd("analog_pin_select rw", `ACS_ADDR_ANALOG_PIN_SELECT, 8'h2A);
        `CHK("analog_pin_select port", 7'h2A, analog_pin_select_r)
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            conv(1'(i / 3), 2'(i % 3), DIV_T[i]);
        end
        conv(1'($random(seed)), `ACS_SRC_RC, 40);
        // abort in mid conversion keeps the old result
        wr(`ACS_ADDR_CONFIG, 8'h50);
        wr(`ACS_ADDR_CTRL0, 8'h81);
        repeat (4) @(posedge clock);
        sar_result <= ~sar_result;
        conv_cnt = 0;
        hold_cnt = 0;
        armed    = 1'b1;
        wr(`ACS_ADDR_CTRL0, 8'h85);
        repeat (100) @(posedge clock);
        wr(`ACS_ADDR_CTRL0, 8'h81);
        wait_idle();
        `CHK("abort length", 1'b1, conv_cnt < 9 * 64)
        `CHK("abort hold", 1'b1, hold_cnt >= 128 && hold_cnt <= 132)
        `CHK("abort flag", 1'b0, conversion_done_flag_r)
        rd("abort hi", `ACS_ADDR_RES_HI, res_hi);
        rd("abort lo", `ACS_ADDR_RES_LO, res_lo);
        $display("test abort done");
        // power off in mid conversion stops at once
        wr(`ACS_ADDR_CTRL0, 8'h85);
        repeat (20) @(posedge clock);
        wr(`ACS_ADDR_CTRL0, 8'h80);
        @(negedge clock);
        `CHK("off stop", 1'b0, converting_r)
        rd("off go", `ACS_ADDR_CTRL0, 8'h80);
        $display("test power off done");
        // go in the write that powers on is ignored
        wr(`ACS_ADDR_CTRL0, 8'h00);
        wr(`ACS_ADDR_CTRL0, 8'h05);
        rd("go refused", `ACS_ADDR_CTRL0, 8'h01);
        `CHK("no convert", 1'b0, converting_r)
        $display("test refused go done");
        repeat (4) @(posedge clock);
        end_sim();
    end
endmodule : test_adc_conversion_sequencer
